// ===== tih_irq_source.sv
// interrupt sources holding level lines until their own acknowledge
`timescale 1ns/1ps
`include "tih_params.svh"

module tih_irq_source (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // raise requests from the bench
    input wire logic [31:0] raise_i,
    // acknowledge from the unit
    input wire logic ack_i,
    input wire logic [4:0] ack_index_i,
    // level lines towards the unit
    output logic [31:0] lines_o
);
    logic [31:0] next_lines;

    // reserved lines stay low; a raised line holds until its own index is acknowledged
    always_comb begin
        next_lines = lines_o | (raise_i & `TIH_LINE_VALID);
        if (ack_i) begin
            next_lines[ack_index_i] = 1'b0;
        end
    end

    // registered line levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines_o <= `TIH_RST_WORD;
        end else begin
            lines_o <= next_lines;
        end
    end
endmodule

// ===== tih_params.svh
// constants for the trap and interrupt handling unit
`ifndef TIH_PARAMS_SVH
`define TIH_PARAMS_SVH

// register offsets on the bus (byte addresses)
`define TIH_OFF_STATUS 8'h00
`define TIH_OFF_ENABLE 8'h04
`define TIH_OFF_PENDING 8'h08
`define TIH_OFF_VBASE 8'h0c
`define TIH_OFF_RETPC 8'h10
`define TIH_OFF_CAUSE 8'h14

// status register field positions
`define TIH_ST_GIE 3
`define TIH_ST_PIE 7

// trap vector base fields
`define TIH_VBASE_MASK 32'hffff_ff00
`define TIH_VBASE_MODE_MASK 32'h0000_0003

// cause register fields and exception codes
`define TIH_CAUSE_IRQ_BIT 31
`define TIH_CAUSE_ILLEGAL 5'h02
`define TIH_CAUSE_BREAK 5'h03
`define TIH_CAUSE_ECALL 5'h0b

// interrupt line numbers and usable lines
`define TIH_LINE_EXT 11
`define TIH_LINE_TIMER 7
`define TIH_LINE_SOFT 3
`define TIH_LINE_CUSTOM_LO 16
`define TIH_LINE_CUSTOM_HI 31
`define TIH_LINE_VALID 32'hffff_0888

// reset values
`define TIH_RST_WORD 32'h0000_0000

`endif

// ===== tih_pkg.sv
// types for the trap and interrupt handling unit
package tih_pkg;

    // trap vector mode field encoding
    typedef enum logic [1:0] {
        TIH_VEC_DIRECT = 2'b00,
        TIH_VEC_VECTORED = 2'b01
    } tih_vec_mode_t;

    // kind of fetch redirection decided in a cycle
    typedef enum logic [2:0] {
        TIH_TRAP_NONE = 3'b000,
        TIH_TRAP_BOOT = 3'b001,
        TIH_TRAP_EXC = 3'b010,
        TIH_TRAP_RET = 3'b011,
        TIH_TRAP_IRQ = 3'b100
    } tih_trap_t;

endpackage

// ===== tih_trap_unit.sv
// trap and interrupt handling unit with a classic wishbone register slave
// Notes on behaviour
// - entry saves pc and global enable
// - exceptions always jump to vector base
// - direct mode interrupts jump to base
// - vectored mode adds four times index
// - return restores pc and global enable
// - first fetch after reset from boot input
// - interrupt lines active high, level sensitive
// - lines 11, 7, 3 are standard
// - one-cycle taken pulse with index
// - reset disables all interrupts
// - take needs global and line enable
// - upper mask bits serve custom lines
// - fixed priority: 31..16, 11, 3, 7
// - no interrupts while in debug mode
// - exception codes only 2, 3, 11
// - illegal and ecall cannot be disabled
// - illegal covers undefined and disabled extensions
// - entry clears global enable; one saved level only
// - no hardware nesting beyond saved pc
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "tih_params.svh"

module tih_trap_unit #(
    parameter logic FLOAT_UNIT_PARAM = 1'b0,
    parameter logic CUSTOM_EXT_PARAM = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // core pipeline side
    input wire logic [31:0] pc_i,
    input wire logic [31:0] boot_location_i,
    input wire logic instr_valid_i,
    input wire logic undef_instr_i,
    input wire logic float_instr_i,
    input wire logic custom_instr_i,
    input wire logic ebreak_i,
    input wire logic ecall_i,
    input wire logic trap_return_i,
    input wire logic debug_mode_i,
    // interrupt lines from the sources
    input wire logic [31:0] interrupt_lines_i,
    // fetch redirection
    output logic fetch_redirect_o,
    output logic [31:0] fetch_target_o,
    output logic global_irq_enable_o,
    // acknowledge to the interrupt controller
    output logic interrupt_taken_pulse_o,
    output logic [4:0] taken_interrupt_index_o
);

    // register state
    logic global_irq_enable;
    logic prior_irq_enable;
    logic [31:0] irq_enable_mask;
    logic [31:0] trap_vector_base;
    logic [31:0] trap_return_pc;
    logic [31:0] trap_cause;
    logic boot_pending, ack, redirect, taken;
    logic [31:0] irq_meta;
    logic [31:0] irq_level;
    logic [31:0] rdata;
    logic [31:0] target;
    logic [4:0] taken_idx;

    // next values
    logic next_global_irq_enable;
    logic next_prior_irq_enable;
    logic [31:0] next_irq_enable_mask;
    logic [31:0] next_trap_vector_base;
    logic [31:0] next_trap_return_pc;
    logic [31:0] next_trap_cause;
    logic next_boot_pending, next_ack, next_redirect, next_taken;
    logic [31:0] next_rdata;
    logic [31:0] next_target;
    logic [4:0] next_taken_idx;

    // decision signals
    logic [31:0] wmask;
    logic bus_req, bus_hit, bus_wr, irq_any, illegal, exc_any;
    logic [31:0] irq_pending_mask;
    logic [31:0] irq_cand;
    logic [4:0] irq_idx;
    logic [4:0] exc_code;
    logic [31:0] vec_base;
    tih_pkg::tih_trap_t trap_kind;

    // byte enables widened to a bit mask
    genvar b;
    generate
        for (b = 0; b < 4; b = b + 1) begin : g_wmask
            assign wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
        end
    endgenerate

    // two flip-flop synchroniser on the level lines
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_meta <= `TIH_RST_WORD;
            irq_level <= `TIH_RST_WORD;
        end else begin
            irq_meta <= interrupt_lines_i;
            irq_level <= irq_meta;
        end
    end

    // bus request decode
    assign bus_req = wb_cyc_i && wb_stb_i && !ack;
    assign bus_hit = (wb_adr_i[31:8] == 24'h00_0000);
    assign bus_wr = bus_req && wb_we_i && bus_hit;

    // pending lines: only usable positions, custom lines at their own bit
    assign irq_pending_mask = irq_level & `TIH_LINE_VALID;

    // candidate interrupts gated by global and per-line enables and debug
    assign irq_cand = (global_irq_enable && !debug_mode_i) ?
        (irq_pending_mask & irq_enable_mask) : 32'h0000_0000;
    assign irq_any = (irq_cand != 32'h0000_0000);

    // fixed priority pick, later assignments win
    always_comb begin
        irq_idx = 5'h00;
        if (irq_cand[`TIH_LINE_TIMER]) irq_idx = 5'(`TIH_LINE_TIMER);
        if (irq_cand[`TIH_LINE_SOFT]) irq_idx = 5'(`TIH_LINE_SOFT);
        if (irq_cand[`TIH_LINE_EXT]) irq_idx = 5'(`TIH_LINE_EXT);
        for (int i = `TIH_LINE_CUSTOM_LO; i <= `TIH_LINE_CUSTOM_HI; i++) begin
            if (irq_cand[i]) irq_idx = 5'(i);
        end
    end

    // exception detection; illegal and ecall have no enable
    assign illegal = undef_instr_i || (float_instr_i && !FLOAT_UNIT_PARAM) ||
        (custom_instr_i && !CUSTOM_EXT_PARAM);
    assign exc_any = instr_valid_i && (illegal || ecall_i || ebreak_i);
    assign exc_code = illegal ? `TIH_CAUSE_ILLEGAL :
        (ecall_i ? `TIH_CAUSE_ECALL : `TIH_CAUSE_BREAK);

    // aligned base; low byte is forced to zero
    assign vec_base = trap_vector_base & `TIH_VBASE_MASK;

    // redirection kind by priority: boot, exception, return, interrupt
    always_comb begin
        if (boot_pending) begin
            trap_kind = tih_pkg::TIH_TRAP_BOOT;
        end else if (exc_any) begin
            trap_kind = tih_pkg::TIH_TRAP_EXC;
        end else if (instr_valid_i && trap_return_i) begin
            trap_kind = tih_pkg::TIH_TRAP_RET;
        end else if (irq_any) begin
            trap_kind = tih_pkg::TIH_TRAP_IRQ;
        end else begin
            trap_kind = tih_pkg::TIH_TRAP_NONE;
        end
    end

    // next values of registers, bus answer and fetch outputs
    always_comb begin
        next_global_irq_enable = global_irq_enable;
        next_prior_irq_enable = prior_irq_enable;
        next_irq_enable_mask = irq_enable_mask;
        next_trap_vector_base = trap_vector_base;
        next_trap_return_pc = trap_return_pc;
        next_trap_cause = trap_cause;
        next_boot_pending = 1'b0;
        next_rdata = rdata;
        next_ack = bus_req;
        next_redirect = 1'b0;
        next_target = target;
        next_taken = 1'b0;
        next_taken_idx = taken_idx;
        // software writes, byte lanes honoured
        if (bus_wr) begin
            case (wb_adr_i[7:0])
                `TIH_OFF_STATUS: begin
                    if (wb_sel_i[0]) begin
                        next_global_irq_enable = wb_dat_i[`TIH_ST_GIE];
                        next_prior_irq_enable = wb_dat_i[`TIH_ST_PIE];
                    end
                end
                `TIH_OFF_ENABLE: begin
                    next_irq_enable_mask = ((irq_enable_mask & ~wmask) |
                        (wb_dat_i & wmask)) & `TIH_LINE_VALID;
                end
                `TIH_OFF_VBASE: begin
                    next_trap_vector_base = ((trap_vector_base & ~wmask) |
                        (wb_dat_i & wmask)) &
                        (`TIH_VBASE_MASK | `TIH_VBASE_MODE_MASK);
                end
                `TIH_OFF_RETPC: begin
                    next_trap_return_pc = (trap_return_pc & ~wmask) | (wb_dat_i & wmask);
                end
                default: ;
            endcase
        end
        // read data, unmapped reads return zero
        if (bus_req) begin
            next_rdata = 32'h0000_0000;
            if (!wb_we_i && bus_hit) begin
                case (wb_adr_i[7:0])
                    `TIH_OFF_STATUS: begin
                        next_rdata[`TIH_ST_GIE] = global_irq_enable;
                        next_rdata[`TIH_ST_PIE] = prior_irq_enable;
                    end
                    `TIH_OFF_ENABLE: next_rdata = irq_enable_mask;
                    `TIH_OFF_PENDING: next_rdata = irq_pending_mask;
                    `TIH_OFF_VBASE: next_rdata = trap_vector_base;
                    `TIH_OFF_RETPC: next_rdata = trap_return_pc;
                    `TIH_OFF_CAUSE: next_rdata = trap_cause;
                    default: next_rdata = 32'h0000_0000;
                endcase
            end
        end
        // hardware trap actions win over a software write in the same cycle
        case (trap_kind)
            tih_pkg::TIH_TRAP_BOOT: begin
                next_redirect = 1'b1;
                next_target = boot_location_i;
            end
            tih_pkg::TIH_TRAP_EXC: begin
                next_trap_return_pc = pc_i;
                next_prior_irq_enable = global_irq_enable;
                next_global_irq_enable = 1'b0;
                next_trap_cause = {27'h000_0000, exc_code};
                next_redirect = 1'b1;
                next_target = vec_base;
            end
            tih_pkg::TIH_TRAP_RET: begin
                next_global_irq_enable = prior_irq_enable;
                next_redirect = 1'b1;
                next_target = trap_return_pc;
            end
            tih_pkg::TIH_TRAP_IRQ: begin
                next_trap_return_pc = pc_i;
                next_prior_irq_enable = global_irq_enable;
                next_global_irq_enable = 1'b0;
                next_trap_cause = {1'b1, 26'h000_0000, irq_idx};
                next_redirect = 1'b1;
                if (trap_vector_base[1:0] == tih_pkg::TIH_VEC_VECTORED) begin
                    next_target = vec_base + {25'h000_0000, irq_idx, 2'b00};
                end else begin
                    next_target = vec_base;
                end
                next_taken = 1'b1;
                next_taken_idx = irq_idx;
            end
            default: ;
        endcase
    end

    // register all state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            global_irq_enable <= 1'b0;
            prior_irq_enable <= 1'b0;
            irq_enable_mask <= `TIH_RST_WORD;
            trap_vector_base <= `TIH_RST_WORD;
            trap_return_pc <= `TIH_RST_WORD;
            trap_cause <= `TIH_RST_WORD;
            boot_pending <= 1'b1;
            rdata <= `TIH_RST_WORD;
            ack <= 1'b0;
            redirect <= 1'b0;
            target <= `TIH_RST_WORD;
            taken <= 1'b0;
            taken_idx <= 5'h00;
        end else begin
            global_irq_enable <= next_global_irq_enable;
            prior_irq_enable <= next_prior_irq_enable;
            irq_enable_mask <= next_irq_enable_mask;
            trap_vector_base <= next_trap_vector_base;
            trap_return_pc <= next_trap_return_pc;
            trap_cause <= next_trap_cause;
            boot_pending <= next_boot_pending;
            rdata <= next_rdata;
            ack <= next_ack;
            redirect <= next_redirect;
            target <= next_target;
            taken <= next_taken;
            taken_idx <= next_taken_idx;
        end
    end

    // outputs
    assign wb_dat_o = rdata;
    assign wb_ack_o = ack;
    assign fetch_redirect_o = redirect;
    assign fetch_target_o = target;
    assign global_irq_enable_o = global_irq_enable;
    assign interrupt_taken_pulse_o = taken;
    assign taken_interrupt_index_o = taken_idx;

    // entry saves pc and global enable into the return pc and prior enable
    entry_save_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(trap_kind == tih_pkg::TIH_TRAP_EXC || trap_kind == tih_pkg::TIH_TRAP_IRQ)
        |-> (trap_return_pc == $past(pc_i)) && (prior_irq_enable == $past(global_irq_enable)))
        else $error("trap entry did not save pc and enable");

    // exceptions go to the aligned base
    exc_vector_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(trap_kind == tih_pkg::TIH_TRAP_EXC)
        |-> fetch_redirect_o && (fetch_target_o == ($past(trap_vector_base) & 32'hffff_ff00)))
        else $error("exception target is not the vector base");

    // direct mode interrupt target
    direct_vector_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o && ($past(trap_vector_base[1:0]) == 2'b00)
        |-> fetch_target_o == ($past(trap_vector_base) & 32'hffff_ff00))
        else $error("direct mode target wrong");

    // vectored mode interrupt target
    vectored_target_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o && ($past(trap_vector_base[1:0]) == 2'b01)
        |-> fetch_target_o == (($past(trap_vector_base) & 32'hffff_ff00) +
            {25'h000_0000, taken_interrupt_index_o, 2'b00}))
        else $error("vectored mode target wrong");

    // return restores pc and enable
    return_restore_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(trap_kind == tih_pkg::TIH_TRAP_RET)
        |-> fetch_redirect_o && (fetch_target_o == $past(trap_return_pc)) &&
            (global_irq_enable == $past(prior_irq_enable)))
        else $error("trap return did not restore state");

    // first redirect after reset uses the boot location
    boot_fetch_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $fell(boot_pending) |-> fetch_redirect_o && (fetch_target_o == $past(boot_location_i)))
        else $error("boot fetch address wrong");

    // reset leaves interrupts disabled
    reset_disable_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> !global_irq_enable && (irq_enable_mask == 32'h0000_0000))
        else $error("interrupts enabled after reset");

    // taken pulse lasts exactly one cycle
    taken_pulse_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o |=> !interrupt_taken_pulse_o)
        else $error("taken pulse longer than one cycle");

    // taken interrupt was enabled and pending
    enable_gate_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o |-> $past(global_irq_enable) &&
            $past(irq_enable_mask[irq_idx]) && $past(irq_level[irq_idx]) &&
            ($past(irq_idx) == taken_interrupt_index_o))
        else $error("disabled interrupt was taken");

    // timer only wins when it is the sole candidate
    timer_lowest_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o && (taken_interrupt_index_o == 5'h07)
        |-> ($past(irq_cand) & 32'hffff_ff7f) == 32'h0000_0000)
        else $error("timer taken over a higher interrupt");

    // debug mode blocks all interrupts
    debug_block_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(debug_mode_i) |-> !interrupt_taken_pulse_o)
        else $error("interrupt taken in debug mode");

    // exception cause codes and interrupt flag
    cause_code_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $past(trap_kind == tih_pkg::TIH_TRAP_EXC)
        |-> !trap_cause[31] && (trap_cause[4:0] == 5'h02 || trap_cause[4:0] == 5'h03 ||
            trap_cause[4:0] == 5'h0b))
        else $error("bad exception cause code");

    // interrupt cause records flag and index
    irq_cause_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        interrupt_taken_pulse_o |-> trap_cause[31] &&
            (trap_cause[4:0] == taken_interrupt_index_o) && !global_irq_enable)
        else $error("interrupt cause not recorded");

endmodule

// ===== tih_trap_unit_test.sv
// self-checking bench for the trap and interrupt handling unit
`timescale 1ns/1ps
`include "tih_params.svh"

module tih_trap_unit_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid_i, debug_mode_i;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, pc_i, boot_location_i, lines, raise;
    logic [31:0] fetch_target_o, rd, vbase, pend, tmp;
    logic [3:0] wb_sel_i;
    logic [5:0] ins;
    logic [4:0] taken_interrupt_index_o, idx;
    logic fetch_redirect_o, global_irq_enable_o, interrupt_taken_pulse_o;
    logic [1:0] mode;
    int n_fail = 0;
    int num_checks = 0;
    logic [4:0] codes [5] = '{`TIH_CAUSE_ILLEGAL, `TIH_CAUSE_ILLEGAL, `TIH_CAUSE_ILLEGAL,
        `TIH_CAUSE_BREAK, `TIH_CAUSE_ECALL};

    // clock at 200 MHz
    always #2.5 clk_i = ~clk_i;

    tih_trap_unit #(.FLOAT_UNIT_PARAM(1'b0), .CUSTOM_EXT_PARAM(1'b0)) DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pc_i(pc_i),
        .boot_location_i(boot_location_i), .instr_valid_i(instr_valid_i),
        .undef_instr_i(ins[0]), .float_instr_i(ins[1]), .custom_instr_i(ins[2]),
        .ebreak_i(ins[3]), .ecall_i(ins[4]), .trap_return_i(ins[5]),
        .debug_mode_i(debug_mode_i), .interrupt_lines_i(lines),
        .fetch_redirect_o(fetch_redirect_o), .fetch_target_o(fetch_target_o),
        .global_irq_enable_o(global_irq_enable_o),
        .interrupt_taken_pulse_o(interrupt_taken_pulse_o),
        .taken_interrupt_index_o(taken_interrupt_index_o));

    tih_irq_source src (.clk_i(clk_i), .rst_i(rst_i), .raise_i(raise),
        .ack_i(interrupt_taken_pulse_o), .ack_index_i(taken_interrupt_index_o), .lines_o(lines));

    // fixed priority of pending lines: custom high to low, then 11, 3, 7
    function automatic logic [4:0] prio(input logic [31:0] p);
        for (int i = 31; i >= 16; i--) begin
            if (p[i]) begin
                return 5'(i);
            end
        end
        return p[11] ? 5'd11 : (p[3] ? 5'd3 : 5'd7);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one classic cycle; holds until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] off, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {24'h0000_00, off};
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        chk(wb_ack_o, 1, "bus ack");
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] off, input logic [31:0] exp, input string what);
        bus(1'b0, off, 32'h0000_0000);
        chk(rd, exp, what);
    endtask

    // one qualified instruction of the given kind, then the redirect it must cause
    task automatic instr(input int kind, input logic [31:0] tgt);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        ins <= 6'h01 << kind;
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        ins <= 6'h00;
        @(posedge clk_i);
        chk(fetch_redirect_o, 1, "redirect");
        chk(fetch_target_o, tgt, "target");
    endtask

    // wait for the highest pending interrupt, check entry state, then return
    task automatic take(input logic [31:0] pc, input logic [31:0] base, input logic vec);
        int n;
        n = 0;
        idx = prio(pend);
        do begin
            @(posedge clk_i);
            n++;
        end while (interrupt_taken_pulse_o !== 1'b1 && n < 50);
        chk(taken_interrupt_index_o, idx, "index");
        chk(fetch_target_o, vec ? base + {25'h0, idx, 2'b00} : base, "vector");
        chk(global_irq_enable_o, 0, "enable cleared");
        pend[idx] = 1'b0;
        @(posedge clk_i);
        chk(interrupt_taken_pulse_o, 0, "pulse width");
        rdc(`TIH_OFF_RETPC, pc, "return pc");
        rdc(`TIH_OFF_CAUSE, 32'h8000_0000 | idx, "irq cause");
        rdc(`TIH_OFF_STATUS, 32'h0000_0080, "prior enable");
        instr(5, pc);
        chk(global_irq_enable_o, 1, "enable restored");
    endtask

    task automatic no_pulse(input string what);
        repeat (10) begin
            @(posedge clk_i);
            chk(interrupt_taken_pulse_o, 0, what);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #100000;
        n_fail++;
        end_sim();
    end

    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, instr_valid_i, debug_mode_i} = 5'h00;
        {wb_adr_i, wb_dat_i, raise, pc_i} = 128'h0;
        wb_sel_i = 4'hf;
        ins = 6'h00;
        void'($urandom(32'hc4bb));
        boot_location_i = $urandom;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(fetch_redirect_o, 1, "boot redirect");
        chk(fetch_target_o, boot_location_i, "boot target");
        chk(global_irq_enable_o, 0, "reset enable");
        rdc(`TIH_OFF_STATUS, 32'h0000_0000, "reset status");
        rdc(`TIH_OFF_ENABLE, 32'h0000_0000, "reset mask");
        rdc(8'h40, 32'h0000_0000, "unmapped read");
        $display("test reset done");
        vbase = ($urandom & `TIH_VBASE_MASK) | 32'h0000_0001;
        bus(1'b1, `TIH_OFF_VBASE, vbase);
        for (int k = 0; k < 5; k++) begin
            tmp = $urandom;
            pc_i <= tmp;
            instr(k, vbase & `TIH_VBASE_MASK);
            rdc(`TIH_OFF_CAUSE, {27'h0, codes[k]}, "exception cause");
            rdc(`TIH_OFF_RETPC, tmp, "exception pc");
        end
        $display("test exceptions done");
        bus(1'b1, `TIH_OFF_ENABLE, `TIH_LINE_VALID);
        for (int r = 0; r < 5; r++) begin
            mode = 2'($urandom); // codes 2 and 3 must behave as direct
            vbase = ($urandom & `TIH_VBASE_MASK) | {30'h0, mode};
            bus(1'b1, `TIH_OFF_VBASE, vbase);
            pend = (r == 0) ? `TIH_LINE_VALID : ($urandom & `TIH_LINE_VALID);
            pend = (pend == 0) ? 32'h0000_0080 : pend;
            raise <= pend;
            @(posedge clk_i);
            raise <= 32'h0000_0000;
            tmp = $urandom;
            pc_i <= tmp;
            bus(1'b1, `TIH_OFF_STATUS, 32'h0000_0008);
            while (pend != 0) begin
                take(tmp, vbase & `TIH_VBASE_MASK, mode == 2'b01);
            end
            bus(1'b1, `TIH_OFF_STATUS, 32'h0000_0000);
        end
        $display("test priority done");
        bus(1'b1, `TIH_OFF_ENABLE, `TIH_LINE_VALID & 32'hffff_f7ff);
        pend = 32'h0000_0800;
        raise <= pend;
        @(posedge clk_i);
        raise <= 32'h0000_0000;
        bus(1'b1, `TIH_OFF_STATUS, 32'h0000_0008);
        no_pulse("masked line");
        rdc(`TIH_OFF_PENDING, 32'h0000_0800, "pending line");
        debug_mode_i <= 1'b1;
        bus(1'b1, `TIH_OFF_ENABLE, `TIH_LINE_VALID);
        no_pulse("debug mode");
        debug_mode_i <= 1'b0;
        take(tmp, vbase & `TIH_VBASE_MASK, mode == 2'b01);
        $display("test blocking done");
        end_sim();
    end
endmodule
